//--- design/dacc_pkg.sv
// package: register map, field layout and timing constants of the dual converter common control
package dacc_pkg;

  localparam logic [11:0] ADDR_COMMON  = 12'h000;
  localparam logic [11:0] ADDR_GUARD   = 12'h004;
  localparam logic [11:0] ADDR_CONV1   = 12'h008;
  localparam logic [11:0] ADDR_CONV2   = 12'h00c;
  localparam logic [11:0] ADDR_RESULT1 = 12'h010;
  localparam logic [11:0] ADDR_RESULT2 = 12'h014;

  localparam logic [7:0] COMMON_RESET = 8'h00;
  localparam logic [7:0] GUARD_RESET  = 8'h00;
  localparam logic [7:0] CONV_RESET   = 8'h00;

  localparam int JUSTIFY_BIT   = 7;
  localparam int CLKSEL_LSB    = 4;
  localparam int NEGREF_BIT    = 3;
  localparam int STARTALL_BIT  = 2;
  localparam int POSREF_LSB    = 0;
  localparam int GUARD_B_BIT   = 7;
  localparam int GUARD_A_BIT   = 6;
  localparam int GUARD_POL_BIT = 5;
  localparam int TX_POL_BIT    = 0;
  localparam int CONV_ON_BIT   = 0;
  localparam int CONV_GO_BIT   = 1;
  localparam int CHAN_LSB      = 2;

  localparam logic [2:0] CLK_DIV2  = 3'h0;
  localparam logic [2:0] CLK_DIV8  = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_RC_A  = 3'h3;
  localparam logic [2:0] CLK_DIV4  = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [2:0] CLK_RC_B  = 3'h7;

  localparam logic [1:0] PREF_SUPPLY   = 2'h0;
  localparam logic [1:0] PREF_RESERVED = 2'h1;
  localparam logic [1:0] PREF_PIN      = 2'h2;
  localparam logic [1:0] PREF_FIXED    = 2'h3;

  // a conversion is 11.5 periods: counted as 23 half periods
  localparam logic [4:0] CONV_HALF_PERIODS = 5'h17;
  localparam int         RESULT_BITS       = 10;

  typedef enum logic [1:0] {REF_SUPPLY, REF_EXT_PIN, REF_FIXED, REF_NONE} dacc_pref_t;

  typedef struct packed {
    dacc_pref_t pos_ref;
    logic       neg_ref_ext;
  } dacc_ref_t;

  typedef struct packed {
    logic guard_a_oe;
    logic guard_a;
    logic guard_b_oe;
    logic guard_b;
    logic tx;
  } dacc_guard_t;

endpackage

//--- design/dacc_top.sv
// dual converter common control: clocking, references, start, routing, guard ring
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - three-bit field picks RC clock or system clock divided by 2..64
// - bit period equals one conversion clock period; conversion takes 11.5 periods
// - positive reference: 00 supply, 10 external pin, 11 fixed; 01 reserved
// - negative reference is ground unless its select bit is set, then pin
// - combined start sets the start bit of each converter whose on bit is set; read returns OR of both
// - each converter's channel field picks its sample-and-hold input
// - 24 or 35 channels; three pins and internal sources shared by both
// - non-RC clock derives from system clock and tracks its frequency
// - guard B enable drives guard ring signal onto guard B pin
// - guard A enable drives guard ring signal onto guard A pin
// - guard B constant during a conversion; dual sample flips at second precharge
module dacc_top #(
  parameter int CHAN_BITS = 6,
  parameter int NUM_CHAN  = 35
) (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  input  wire logic                 rc_clk_tick_i,
  input  wire logic                 dual_sample_i,
  input  wire logic [9:0]           sample1_i,
  input  wire logic [9:0]           sample2_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output dacc_pkg::dacc_ref_t       ref_o,
  output logic      [CHAN_BITS-1:0] chan1_o,
  output logic      [CHAN_BITS-1:0] chan2_o,
  output logic      [1:0]           chan_shared_o,
  output logic      [1:0]           converting_o,
  output logic                      conv_tick_o,
  output dacc_pkg::dacc_guard_t     guard_o
);

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode
  logic [7:0] common_reg;
  logic [7:0] guard_reg;
  logic [7:0] conv_reg [2];
  logic [15:0] result [2];
  logic [1:0] go;

  wire access   = psel_i && penable_i;
  wire wr       = access && pwrite_i;
  wire hit_com  = paddr_i == dacc_pkg::ADDR_COMMON;
  wire hit_grd  = paddr_i == dacc_pkg::ADDR_GUARD;
  wire hit_c1   = paddr_i == dacc_pkg::ADDR_CONV1;
  wire hit_c2   = paddr_i == dacc_pkg::ADDR_CONV2;
  wire hit_r1   = paddr_i == dacc_pkg::ADDR_RESULT1;
  wire hit_r2   = paddr_i == dacc_pkg::ADDR_RESULT2;
  wire mapped   = hit_com | hit_grd | hit_c1 | hit_c2 | hit_r1 | hit_r2;
  wire wr_com   = wr && hit_com;
  wire start_all = wr_com && pwdata_i[dacc_pkg::STARTALL_BIT];
  wire [1:0] wr_conv = {wr && hit_c2, wr && hit_c1};

  // combined bit is never stored; it is the OR of the per-converter bits
  wire [7:0] common_rd = {common_reg[7:3], |go, common_reg[1:0]};
  wire [7:0] conv_rd1  = {conv_reg[0][7:2], go[0], conv_reg[0][0]};
  wire [7:0] conv_rd2  = {conv_reg[1][7:2], go[1], conv_reg[1][0]};

  assign pready_o  = 1'b1;
  assign pslverr_o = access && !mapped;

  wire [31:0] next_prdata =
    hit_com ? {24'h000000, common_rd} :
    hit_grd ? {24'h000000, guard_reg} :
    hit_c1  ? {24'h000000, conv_rd1}  :
    hit_c2  ? {24'h000000, conv_rd2}  :
    hit_r1  ? {16'h0000, result[0]}   :
    hit_r2  ? {16'h0000, result[1]}   : 32'h00000000;

  // read data registered on setup so it is stable through the access phase
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prdata_o <= 32'h00000000;
    else if (psel_i && !penable_i)
      prdata_o <= next_prdata;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      common_reg <= dacc_pkg::COMMON_RESET;
      guard_reg  <= dacc_pkg::GUARD_RESET;
    end
    else
    begin
      if (wr_com)
        common_reg <= {pwdata_i[7:3], 1'b0, pwdata_i[1:0]};
      if (wr && hit_grd)
        guard_reg <= {pwdata_i[7:5], 4'h0, pwdata_i[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // references
  wire [1:0] pref = common_reg[dacc_pkg::POSREF_LSB +: 2];

  always_comb
  begin
    case (pref)
      dacc_pkg::PREF_SUPPLY: ref_o.pos_ref = dacc_pkg::REF_SUPPLY;
      dacc_pkg::PREF_PIN:    ref_o.pos_ref = dacc_pkg::REF_EXT_PIN;
      dacc_pkg::PREF_FIXED:  ref_o.pos_ref = dacc_pkg::REF_FIXED;
      default:               ref_o.pos_ref = dacc_pkg::REF_NONE;
    endcase
    ref_o.neg_ref_ext = common_reg[dacc_pkg::NEGREF_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock
  wire [2:0] clk_sel = common_reg[dacc_pkg::CLKSEL_LSB +: 3];
  logic [5:0] prescale;
  logic [5:0] div_mask;

  always_comb
  begin
    case (clk_sel)
      dacc_pkg::CLK_DIV2:  div_mask = 6'h00;
      dacc_pkg::CLK_DIV4:  div_mask = 6'h01;
      dacc_pkg::CLK_DIV8:  div_mask = 6'h03;
      dacc_pkg::CLK_DIV16: div_mask = 6'h07;
      dacc_pkg::CLK_DIV32: div_mask = 6'h0f;
      dacc_pkg::CLK_DIV64: div_mask = 6'h1f;
      default:             div_mask = 6'h00;
    endcase
  end

  wire use_rc = clk_sel == dacc_pkg::CLK_RC_A || clk_sel == dacc_pkg::CLK_RC_B;
  // a half period of the conversion clock: system clock divides track its rate
  wire half_tick = use_rc ? rc_clk_tick_i : (prescale & div_mask) == div_mask;
  assign conv_tick_o = half_tick;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prescale <= 6'h00;
    else
      prescale <= prescale + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-converter control, sequencing and results
  typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} dacc_state_t;
  dacc_state_t state [2];
  logic [4:0] half_cnt [2];
  logic [1:0] done;
  logic [1:0] second_half;

  wire justify_right = common_reg[dacc_pkg::JUSTIFY_BIT];

  for (genvar i = 0; i < 2; i++)
  begin : g_conv
    wire [9:0] sample = (i == 0) ? sample1_i : sample2_i;
    wire conv_on = conv_reg[i][dacc_pkg::CONV_ON_BIT];
    wire next_go_wr = wr_conv[i] && pwdata_i[dacc_pkg::CONV_GO_BIT];
    wire last_half = half_tick && half_cnt[i] == dacc_pkg::CONV_HALF_PERIODS - 5'h01;
    wire more = state[i] == ST_FIRST && dual_sample_i;
    assign done[i] = state[i] != ST_IDLE && last_half && !more;
    assign second_half[i] = state[i] == ST_SECOND;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
        conv_reg[i] <= dacc_pkg::CONV_RESET;
      else if (wr_conv[i])
        conv_reg[i] <= {pwdata_i[7:2], 1'b0, pwdata_i[0]};
    end

    // start wins over completion in the same cycle
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
        go[i] <= 1'b0;
      else if ((start_all || next_go_wr) && conv_on)
        go[i] <= 1'b1;
      else if (done[i] || !conv_on)
        go[i] <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        state[i]    <= ST_IDLE;
        half_cnt[i] <= 5'h00;
      end
      else
      begin
        case (state[i])
          ST_IDLE:
          begin
            half_cnt[i] <= 5'h00;
            if (go[i])
              state[i] <= ST_FIRST;
          end
          ST_FIRST, ST_SECOND:
          begin
            if (!conv_on)
              state[i] <= ST_IDLE;
            else if (last_half)
            begin
              half_cnt[i] <= 5'h00;
              state[i]    <= more ? ST_SECOND : ST_IDLE;
            end
            else if (half_tick)
              half_cnt[i] <= half_cnt[i] + 5'h01;
          end
          default: state[i] <= ST_IDLE;
        endcase
      end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
        result[i] <= 16'h0000;
      else if (done[i])
        result[i] <= justify_right ? {6'h00, sample} : {sample, 6'h00};
    end
  end

  assign converting_o = {state[1] != ST_IDLE, state[0] != ST_IDLE};
  // software waits the acquisition delay after a channel change
  assign chan1_o = conv_reg[0][dacc_pkg::CHAN_LSB +: CHAN_BITS];
  assign chan2_o = conv_reg[1][dacc_pkg::CHAN_LSB +: CHAN_BITS];

  // channels 0..2 are shared pins; internal sources sit above the pin range
  assign chan_shared_o[0] = chan1_o < 3 || chan1_o >= CHAN_BITS'(NUM_CHAN - 3);
  assign chan_shared_o[1] = chan2_o < 3 || chan2_o >= CHAN_BITS'(NUM_CHAN - 3);

  ////////////////////////////////////////////////////////////////////////////
  // guard ring outputs
  wire guard_pol = guard_reg[dacc_pkg::GUARD_POL_BIT];
  wire busy      = state[0] != ST_IDLE;

  always_comb
  begin
    guard_o.guard_b_oe = guard_reg[dacc_pkg::GUARD_B_BIT];
    guard_o.guard_a_oe = guard_reg[dacc_pkg::GUARD_A_BIT];
    // B flat over a conversion, flipped for the second sample only
    guard_o.guard_b    = guard_o.guard_b_oe && (guard_pol ^ second_half[0]);
    guard_o.guard_a    = guard_o.guard_a_oe && (guard_pol ^ busy);
    guard_o.tx         = guard_reg[dacc_pkg::TX_POL_BIT] ^ second_half[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_start_sets_go: assert property (@(posedge clk_i) disable iff (!resetn_i)
    start_all && conv_reg[0][0] |=> go[0]) else $error("combined start missed");

  a_done_clears_go: assert property (@(posedge clk_i) disable iff (!resetn_i)
    done[0] && !start_all && !wr_conv[0] |=> !go[0]) else $error("go not cleared");

  a_right_justify: assert property (@(posedge clk_i) disable iff (!resetn_i)
    done[1] && justify_right |=> result[1][15:10] == 6'h00) else $error("high bits");

  a_left_justify: assert property (@(posedge clk_i) disable iff (!resetn_i)
    done[1] && !justify_right |=> result[1][5:0] == 6'h00) else $error("low bits");

  a_div2_tick: assert property (@(posedge clk_i) disable iff (!resetn_i)
    clk_sel == dacc_pkg::CLK_DIV2 |-> half_tick) else $error("div2 clock");

  // a register write mid-conversion may legally move the pin, so it is excluded
  a_guard_b_flat: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state[0] == ST_FIRST ##1 state[0] == ST_FIRST && $stable(guard_reg)
    |-> $stable(guard_o.guard_b)) else $error("guard b moved");

  a_guard_b_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !guard_reg[7] |-> !guard_o.guard_b_oe && !guard_o.guard_b) else $error("guard b");

  a_neg_ref: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_com |=> ref_o.neg_ref_ext == $past(pwdata_i[3])) else $error("neg ref");

endmodule

//--- testbench/dacc_analog_model.sv
// far-side model: internal rc clock source and the two analog sample values
`timescale 1ns/1ps
module dacc_analog_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [1:0] busy_i,
  input  wire logic [9:0] val1_i,
  input  wire logic [9:0] val2_i,
  output logic            rc_tick_o,
  output logic [9:0]      samp1_o,
  output logic [9:0]      samp2_o
);
  logic [1:0] div;
  logic [2:0] hold;
  wire        valid = (busy_i != 2'h0) || (hold != 3'h0);
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div  <= 2'h0;
      hold <= 3'h0;
    end
    else
    begin
      div  <= div + 2'h1;
      hold <= (busy_i != 2'h0) ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
    end
  end
  // rc half period is four system cycles, unrelated to any divider code
  assign rc_tick_o = (div == 2'h3);
  // outside a conversion and the four cycles after it the input is not held: show the inverse
  assign samp1_o   = valid ? val1_i : ~val1_i;
  assign samp2_o   = valid ? val2_i : ~val2_i;
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the dual converter common control
`timescale 1ns/1ps
module tb_top;
  logic                  clk_i, resetn_i, psel, penable, pwrite, rc_tick, last_err, gb, dual;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata_o, g;
  logic                  pready_o, pslverr_o, conv_tick_o;
  logic [7:0]            cm;
  logic [5:0]            chan1_o, chan2_o, chans[8];
  logic [1:0]            chan_shared_o, converting_o;
  logic [9:0]            v1, v2, s1, s2;
  dacc_pkg::dacc_ref_t   ref_o;
  dacc_pkg::dacc_guard_t guard_o;
  dacc_pkg::dacc_pref_t  pref_t[4];
  logic [31:0]           exp_q[$];
  int                    err_count, n_tests, cyc, nticks, sp, half_t[8];
  integer                seed;
  ////////////////////////////////////////////////////////////////////////////////
  dacc_top i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .rc_clk_tick_i(rc_tick),
    .dual_sample_i(dual), .sample1_i(s1), .sample2_i(s2), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .ref_o(ref_o), .chan1_o(chan1_o),
    .chan2_o(chan2_o), .chan_shared_o(chan_shared_o), .converting_o(converting_o),
    .conv_tick_o(conv_tick_o), .guard_o(guard_o));
  dacc_analog_model i_model (
    .clk_i(clk_i), .resetn_i(resetn_i), .busy_i(converting_o), .val1_i(v1),
    .val2_i(v2), .rc_tick_o(rc_tick), .samp1_o(s1), .samp2_o(s2));
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // entered just after a rising edge, returns just after one
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    last_err = pslverr_o;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task idle;
    while (converting_o !== 2'h0)
      @(negedge clk_i);
    @(posedge clk_i);
  endtask
  // read data is judged at the completing edge against the oldest note
  always @(posedge clk_i)
    if (psel && penable && pready_o === 1'b1 && !pwrite)
      check("prdata", prdata_o, exp_q.pop_front());
  always @(negedge clk_i)
    if (converting_o !== 2'h0 && conv_tick_o === 1'b1)
      nticks++;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h0afe;
    {psel, penable, pwrite, paddr, pwdata, v1, v2, resetn_i, dual} = '0;
    {err_count, n_tests, cyc, nticks} = '0;
    half_t = '{1, 4, 16, 4, 2, 8, 32, 4};
    pref_t = '{dacc_pkg::REF_SUPPLY, dacc_pkg::REF_NONE, dacc_pkg::REF_EXT_PIN,
               dacc_pkg::REF_FIXED};
    chans = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h1f, 6'h20, 6'h21, 6'h22};
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++)
      rd(12'(4 * i), 32'h0);
    check("guard", 32'(guard_o), 32'h0);
    rd(12'h018, 32'h0);
    check("pslverr", 32'(last_err), 32'h1);
    $display("test reset and map done");
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, dacc_pkg::ADDR_CONV1, 32'(chans[i]) << 2);
      apb(1'b1, dacc_pkg::ADDR_CONV2, 32'(chans[7 - i]) << 2);
      check("chan1", 32'(chan1_o), 32'(chans[i]));
      check("chan2", 32'(chan2_o), 32'(chans[7 - i]));
      check("shared", 32'(chan_shared_o), (i < 3 || i > 4) ? 32'h3 : 32'h0);
      rd(dacc_pkg::ADDR_CONV1, 32'(chans[i]) << 2);
    end
    $display("test channels done");
    for (int c = 0; c < 8; c++)
    begin
      v1   <= 10'($random(seed));
      v2   <= 10'($random(seed));
      // last code runs the dual-sample sequence
      dual <= (c == 7);
      g  = 32'($random(seed)) & 32'h000000e1;
      apb(1'b1, dacc_pkg::ADDR_GUARD, g);
      check("guard oe", 32'({guard_o.guard_b_oe, guard_o.guard_a_oe}), 32'(g[7:6]));
      apb(1'b1, dacc_pkg::ADDR_CONV1, 32'h1 | (32'(chans[c]) << 2));
      apb(1'b1, dacc_pkg::ADDR_CONV2, 32'(c % 2));
      repeat (8) @(posedge clk_i);
      cm = {c[1], c[2:0], c[2], 1'b1, c[1:0]};
      nticks = 0;
      apb(1'b1, dacc_pkg::ADDR_COMMON, 32'(cm));
      @(negedge clk_i);
      check("busy", 32'(converting_o), (c % 2) ? 32'h3 : 32'h1);
      check("refs", 32'(ref_o), 32'({pref_t[c % 4], c[2]}));
      check("guard a", 32'(guard_o.guard_a), {31'h0, g[6] && !g[5]});
      check("guard b lvl", 32'(guard_o.guard_b), {31'h0, g[7] && g[5]});
      @(posedge clk_i);
      rd(dacc_pkg::ADDR_COMMON, 32'(cm));
      gb = guard_o.guard_b;
      while (conv_tick_o !== 1'b1)
        @(negedge clk_i);
      @(negedge clk_i);
      sp = 1;
      while (conv_tick_o !== 1'b1 && sp < 100)
      begin
        @(negedge clk_i);
        sp++;
      end
      check("tick spacing", sp, half_t[c]);
      check("guard b", 32'(guard_o.guard_b), 32'(gb));
      if (c == 7)
      begin
        // well inside the second sample of the pair
        repeat (120) @(negedge clk_i);
        check("guard b dual", 32'(guard_o.guard_b), {31'h0, g[7] && !g[5]});
        check("tx dual", 32'(guard_o.tx), {31'h0, !g[0]});
      end
      idle;
      check("ticks", nticks, (c == 7) ? 46 : 23);
      rd(dacc_pkg::ADDR_COMMON, 32'(cm & 8'hfb));
      rd(dacc_pkg::ADDR_RESULT1, c[1] ? {22'h0, v1} : {16'h0, v1, 6'h0});
      if (c % 2)
        rd(dacc_pkg::ADDR_RESULT2, c[1] ? {22'h0, v2} : {16'h0, v2, 6'h0});
      $display("test conversion code %0d done", c);
    end
    close_out;
  end
endmodule
